// [hdl/pfs_regs.vh]
// register offsets, field positions and timing for the flash self-write sequencer
// assumes a 16-bit special-register port on the core clock
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
`define PFS_ADDR_CTRL 16'h0760
`define PFS_ADDR_ADRL 16'h0762
`define PFS_ADDR_ADRH 16'h0764
`define PFS_ADDR_KEY 16'h0766
`define PFS_GO_BIT 15
`define PFS_PROGRAM_ENABLE_BIT_BIT 14
`define PFS_ERR_BIT 13
`define PFS_OP_MSB 6
`define PFS_KEY1 8'h55
`define PFS_KEY2 8'haa
`define PFS_OP_ROW_ERASE 7'h41
`define PFS_OP_ROW_PROG 7'h01
`define PFS_ROW_WORDS 32
`define PFS_PANEL_ROWS 128
`define PFS_CYCLE_NS 2000000
`define PFS_CLK_NS 50
`endif

// [hdl/pfs_sequencer.v]
// flash self-write sequencer: table latches, address capture, key unlock, timed cycle
// assumes the core issues table and register accesses on mclk_in; array is modelled by a memory
//
// Contract
// - erase and program one 32-word row
// - low table ops reach word bits 15:0
// - high table ops reach word bits 23:16
// - address is page byte plus effective address
// - panels of 128 rows, 4K words
// - 32-word latches filled in order, then programmed
// - table write touches latches only, two cycles
// - low address register captures effective address low
// - high address register captures effective address high
// - address registers also directly writable
// - control register selects erase, program, start
// - write-only key 0x55 then 0xaa required
// - go bit 15 starts, hardware clears it
// - cycle lasts 2 ms, core stalls
// - high write stores only source low byte
// - software cannot clear go bit
// - error flag on reset during cycle; the code sets it only from the synchronised abort input while busy
// - done flag set on completion, software clears
`include "pfs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pfs_sequencer #(
  parameter PANELS = 1,
  parameter CYCLE_CNT = `PFS_CYCLE_NS / `PFS_CLK_NS
) (
  input wire mclk_in,
  input wire reset_in,
  input wire cycle_abort_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  output reg [15:0] reg_rdata_out,
  input wire tbl_wr_in,
  input wire tbl_rd_in,
  input wire tbl_high_in,
  input wire tbl_byte_in,
  input wire [7:0] tbl_page_in,
  input wire [15:0] tbl_ea_in,
  input wire [15:0] tbl_wdata_in,
  output reg [15:0] tbl_rdata_out,
  output reg stall_out,
  output reg flash_done_irq_flag_out,
  input wire irq_flag_clr_in
);
  localparam WORDS = PANELS * `PFS_PANEL_ROWS * `PFS_ROW_WORDS;
  // word index width: one panel of rows times words, plus panel select
  localparam AW = $clog2(`PFS_PANEL_ROWS * `PFS_ROW_WORDS) + ((PANELS > 1) ? $clog2(PANELS) : 0);
  localparam S_IDLE = 2'h0;
  localparam S_KEY1 = 2'h1;
  localparam S_ARMED = 2'h2;

  // control word as read back:
  //   bit 15 go, set by software, cleared only by hardware
  //   bit 14 program enable, taken from the last control write made while not busy
  //   bit 13 interrupted-cycle error, survives reset_in
  //   bit 8 second cycle of a table write
  //   bits 6:0 operation, bit 6 high selects erase
  //   all other bits read as zero

  reg [23:0] array_mem [0:WORDS-1];
  reg [23:0] latch_mem [0:`PFS_ROW_WORDS-1];
  reg [15:0] adrl_r;
  reg [7:0] adrh_r;
  reg go_r;
  reg program_enable_bit_r;
  // error flag powers up clear and is deliberately outside reset_in
  reg err_r = 1'b0;
  // abort pin synchroniser; only the second stage is read
  reg abort_s1_r = 1'b0;
  reg abort_s2_r = 1'b0;
  reg [6:0] op_r;
  reg twr_r; // second cycle of a table write
  reg [1:0] key_st_r;
  reg [31:0] cnt_r;
  reg [AW-1:0] row_base_r;
  reg [5:0] row_idx_r;
  reg busy_r;
  integer i;

  // program word index from 24-bit byte address; two address units per word
  function [AW-1:0] word_idx;
    input [23:0] a;
    begin
      word_idx = a[AW:1];
    end
  endfunction

  // true on the edge that ends the row walk; shared by go bit and flag
  function walk_end;
    input busy;
    input [31:0] cnt;
    input [5:0] idx;
    begin
      walk_end = busy && cnt == 32'h0000_0000 && idx[5];
    end
  endfunction

  // array cell for one step of the row walk; base is already row aligned
  function [AW-1:0] cell_idx;
    input [AW-1:0] base;
    input [4:0] step;
    begin
      cell_idx = base | {{(AW-5){1'b0}}, step};
    end
  endfunction

  wire [23:0] tbl_addr = {tbl_page_in, tbl_ea_in};
  wire [AW-1:0] tbl_w = word_idx(tbl_addr);
  wire [4:0] lat_i = tbl_w[4:0];
  wire wr_ctrl = reg_wr_in && reg_addr_in == `PFS_ADDR_CTRL;
  wire wr_key = reg_wr_in && reg_addr_in == `PFS_ADDR_KEY;
  wire any_acc = reg_wr_in || reg_rd_in || tbl_wr_in || tbl_rd_in;
  wire go_req = wr_ctrl && reg_wdata_in[`PFS_GO_BIT];
  // key must be armed by the two writes just before this one
  wire key_ok = key_st_r == S_ARMED;
  // enable taken from the go write, so a single write can both enable and start
  wire en_ok = reg_wdata_in[`PFS_PROGRAM_ENABLE_BIT_BIT];
  // a go while busy is dropped; the running cycle cannot be restarted
  wire start = go_req && key_ok && en_ok && !busy_r;
  wire is_erase = op_r[`PFS_OP_MSB];
  // last edge of the cycle
  wire cyc_end = walk_end(busy_r, cnt_r, row_idx_r);

  // key tracking; anything other than the next expected access drops it
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      key_st_r <= S_IDLE;
    end else if (wr_key && reg_wdata_in[7:0] == `PFS_KEY1) begin
      key_st_r <= S_KEY1;
    end else if (wr_key && key_st_r == S_KEY1 && reg_wdata_in[7:0] == `PFS_KEY2) begin
      key_st_r <= S_ARMED;
    end else if (any_acc) begin
      key_st_r <= S_IDLE;
    end
  end

  // control and done flag registers
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      go_r <= 1'b0;
      program_enable_bit_r <= 1'b0;
      op_r <= 7'h00;
      flash_done_irq_flag_out <= 1'b0;
    end else begin
      if (wr_ctrl && !busy_r) begin
        program_enable_bit_r <= reg_wdata_in[`PFS_PROGRAM_ENABLE_BIT_BIT];
        op_r <= reg_wdata_in[`PFS_OP_MSB:0];
      end
      // software writes of a zero go bit are simply not looked at
      if (start) begin
        go_r <= 1'b1;
      end else if (cyc_end) begin
        go_r <= 1'b0;
      end
      // completion wins over a clear in the same cycle
      if (cyc_end) begin
        flash_done_irq_flag_out <= 1'b1;
      end else if (irq_flag_clr_in) begin
        flash_done_irq_flag_out <= 1'b0;
      end
    end
  end

  // address registers have no reset: they must survive a reset that cuts a cycle
  // a table access wins over a direct write in the same cycle
  always @(posedge mclk_in) begin
    if (tbl_wr_in || tbl_rd_in) begin
      adrl_r <= tbl_ea_in;
      adrh_r <= tbl_page_in;
    end else if (reg_wr_in && !busy_r && reg_addr_in == `PFS_ADDR_ADRL) begin
      adrl_r <= reg_wdata_in;
    end else if (reg_wr_in && !busy_r && reg_addr_in == `PFS_ADDR_ADRH) begin
      adrh_r <= reg_wdata_in[7:0];
    end
  end

  // two-flop synchroniser for the abort pin, which comes from outside the clock
  always @(posedge mclk_in) begin
    abort_s1_r <= cycle_abort_in;
    abort_s2_r <= abort_s1_r;
  end

  // error flag survives the sequencer reset; only the abort input or software touch it
  // the abort is seen two edges late, so it must stand while the cycle still runs
  // set wins over a software clear in the same cycle
  always @(posedge mclk_in) begin
    if (busy_r && abort_s2_r) begin
      err_r <= 1'b1;
    end else if (wr_ctrl && !reg_wdata_in[`PFS_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  // cycle timer, then a 32-step row walk; core is stalled throughout
  // total stall is the timer load plus 33 edges for the walk and the end
  // limitation: the length is fixed by CYCLE_CNT, not by any cell behaviour
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
      row_idx_r <= 6'h00;
      row_base_r <= {AW{1'b0}};
      stall_out <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
      stall_out <= 1'b1;
      cnt_r <= CYCLE_CNT[31:0];
      row_idx_r <= 6'h00;
      // row chosen by the address registers, aligned to 32 words
      row_base_r <= word_idx({adrh_r, adrl_r}) & ~{{(AW-5){1'b0}}, 5'h1f};
    end else if (busy_r) begin
      if (cnt_r != 32'h0000_0000) begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end else if (!row_idx_r[5]) begin
        row_idx_r <= row_idx_r + 6'h01;
      end else begin
        busy_r <= 1'b0;
        stall_out <= 1'b0;
      end
    end
  end

  // array update during the row walk; erase sets cells to ones
  always @(posedge mclk_in) begin
    if (busy_r && cnt_r == 32'h0000_0000 && !row_idx_r[5]) begin
      if (is_erase) begin
        array_mem[cell_idx(row_base_r, row_idx_r[4:0])] <= 24'hffffff;
      end else begin
        // latches are kept after programming, so a second go rewrites the same data
        array_mem[cell_idx(row_base_r, row_idx_r[4:0])] <= latch_mem[row_idx_r[4:0]];
      end
    end
  end

  // table writes land in the latches only; byte lane by address bit 0
  // writes while busy are dropped so the row being walked cannot change
  always @(posedge mclk_in) begin
    if (tbl_wr_in && !busy_r) begin
      if (tbl_high_in) begin
        latch_mem[lat_i][23:16] <= tbl_wdata_in[7:0];
      end else if (!tbl_byte_in) begin
        latch_mem[lat_i][15:0] <= tbl_wdata_in;
      end else if (tbl_addr[0]) begin
        latch_mem[lat_i][15:8] <= tbl_wdata_in[7:0];
      end else begin
        latch_mem[lat_i][7:0] <= tbl_wdata_in[7:0];
      end
    end
  end

  // two-cycle table write marker; latch update happens in the first cycle
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      twr_r <= 1'b0;
    end else begin
      twr_r <= tbl_wr_in && !twr_r;
    end
  end

  // read data, registered; it holds until the next read of its kind
  // table reads see the array, never the latches
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
      tbl_rdata_out <= 16'h0000;
    end else begin
      if (reg_rd_in) begin
        case (reg_addr_in)
          `PFS_ADDR_CTRL: reg_rdata_out <= {go_r, program_enable_bit_r, err_r, 4'h0, twr_r, 1'b0, op_r};
          `PFS_ADDR_ADRL: reg_rdata_out <= adrl_r;
          `PFS_ADDR_ADRH: reg_rdata_out <= {8'h00, adrh_r};
          default: reg_rdata_out <= 16'h0000; // key port is write-only
        endcase
      end
      if (tbl_rd_in) begin
        if (tbl_high_in) begin
          tbl_rdata_out <= {8'h00, array_mem[tbl_w][23:16]};
        end else if (!tbl_byte_in) begin
          tbl_rdata_out <= array_mem[tbl_w][15:0];
        end else if (tbl_addr[0]) begin
          tbl_rdata_out <= {8'h00, array_mem[tbl_w][15:8]};
        end else begin
          tbl_rdata_out <= {8'h00, array_mem[tbl_w][7:0]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/pfs_monitor.sv]
// port checker for the flash self-write sequencer
// assumes it is bound onto pfs_sequencer and sees only its ports
`include "pfs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pfs_monitor #(
  parameter CYCLE_CNT = 20
) (
  input wire mclk_in,
  input wire reset_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire stall_out,
  input wire flash_done_irq_flag_out,
  input wire irq_flag_clr_in,
  input wire tbl_wr_in,
  input wire tbl_rd_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  reg [31:0] run_r;
  wire ctl_wr = reg_wr_in && reg_addr_in == `PFS_ADDR_CTRL;
  wire key_wr = reg_wr_in && reg_addr_in == `PFS_ADDR_KEY;
  reg [1:0] seen_r;
  // key progress: 0x55, then 0xaa, with no other access between
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) seen_r <= 2'h0;
    else if (key_wr && reg_wdata_in[7:0] == 8'h55) seen_r <= 2'h1;
    else if (key_wr && seen_r == 2'h1 && reg_wdata_in[7:0] == 8'haa) seen_r <= 2'h2;
    else if (reg_wr_in || reg_rd_in || tbl_wr_in || tbl_rd_in) seen_r <= 2'h0;
  end
  // stalled cycles so far, so the cycle length can be timed exactly
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) run_r <= 32'h0;
    else run_r <= stall_out ? run_r + 32'h1 : 32'h0;
  end
  a_go_needs_write: assert property ($rose(stall_out) |-> $past(ctl_wr && reg_wdata_in[15] && reg_wdata_in[14]))
    else $error("stall began without a go write carrying the enable");
  a_key_order: assert property ($rose(stall_out) |-> $past(seen_r == 2'h2))
    else $error("stall began without back-to-back unlock keys");
  a_cycle_time: assert property ($fell(stall_out) |-> run_r == CYCLE_CNT + 33)
    else $error("erase or program cycle had the wrong length");
  a_stall_bound: assert property (stall_out |-> run_r <= CYCLE_CNT + 33)
    else $error("stall ran past the cycle length");
  a_done_on_end: assert property ($fell(stall_out) |-> flash_done_irq_flag_out)
    else $error("done flag not set at cycle end");
  a_done_sticky: assert property (flash_done_irq_flag_out && !irq_flag_clr_in |=> flash_done_irq_flag_out)
    else $error("done flag dropped without a clear");
  a_done_clear: assert property (irq_flag_clr_in && !stall_out |=> !flash_done_irq_flag_out)
    else $error("done flag survived a clear");
  a_go_reads_set: assert property (reg_rd_in && reg_addr_in == `PFS_ADDR_CTRL && stall_out |=> reg_rdata_out[15])
    else $error("go bit read low while busy");
  a_key_reads_zero: assert property (reg_rd_in && reg_addr_in == `PFS_ADDR_KEY |=> reg_rdata_out == 16'h0000)
    else $error("key register read back nonzero");
  a_read_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  cover property ($rose(stall_out));
  cover property ($fell(stall_out));
  cover property (irq_flag_clr_in && flash_done_irq_flag_out);
endmodule
bind pfs_sequencer pfs_monitor #(.CYCLE_CNT(CYCLE_CNT)) pfs_monitor_i (.*);
`default_nettype wire

// [verif/pfs_core_model.sv]
// processor core stand-in issuing register and table accesses
// assumes strobes are sampled on the rising edge; it drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module pfs_core_model (
  input wire logic mclk_in,
  output logic rw_out = 1'b0,
  output logic rr_out = 1'b0,
  output logic [15:0] addr_out = 16'h0,
  output logic [15:0] wd_out = 16'h0,
  output logic tw_out = 1'b0,
  output logic tr_out = 1'b0,
  output logic hi_out = 1'b0,
  output logic by_out = 1'b0,
  output logic [7:0] page_out = 8'h0,
  output logic [15:0] ea_out = 16'h0
);
  // one-cycle register access; released data is scrambled so stale values never match
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    begin
      @(negedge mclk_in);
      rw_out = w;
      rr_out = !w;
      addr_out = a;
      wd_out = d;
      @(negedge mclk_in);
      rw_out = 1'b0;
      rr_out = 1'b0;
      wd_out = ~d;
    end
  endtask
  // one table instruction, shares the source bus with register writes
  task tbl(input logic w, input logic h, input logic [7:0] p, input logic [15:0] e, input logic [15:0] d);
    begin
      @(negedge mclk_in);
      tw_out = w;
      tr_out = !w;
      hi_out = h;
      page_out = p;
      ea_out = e;
      wd_out = d;
      @(negedge mclk_in);
      tw_out = 1'b0;
      tr_out = 1'b0;
      wd_out = ~d;
    end
  endtask
  // one table read in byte mode
  task tbyte(input logic h, input logic [15:0] e);
    begin
      by_out = 1'b1;
      tbl(1'b0, h, 8'h00, e, 16'h0);
      by_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [verif/program_flash_self_write_sequencer_tb.sv]
// self-checking bench for the flash self-write sequencer
// assumes pfs_core_model as the core and pfs_monitor bound onto the design
`include "pfs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module program_flash_self_write_sequencer_tb;
  localparam CYC = 20;
  localparam [15:0] CT = `PFS_ADDR_CTRL;
  localparam [15:0] AL = `PFS_ADDR_ADRL;
  localparam [15:0] AH = `PFS_ADDR_ADRH;
  localparam [15:0] KY = `PFS_ADDR_KEY;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic abort = 1'b0;
  logic clr = 1'b0;
  wire rw, rr, tw, tr, hi, by, stall, done;
  wire [7:0] page;
  wire [15:0] addr, wd, ea, rdata, tdata;
  integer n_errors = 0;
  integer compares = 0;
  integer ticks = 0;
  integer i;
  pfs_core_model pfs_core_model_i (.mclk_in(mclk_in), .rw_out(rw), .rr_out(rr), .addr_out(addr), .wd_out(wd),
    .tw_out(tw), .tr_out(tr), .hi_out(hi), .by_out(by), .page_out(page), .ea_out(ea));
  pfs_sequencer #(.CYCLE_CNT(CYC)) pfs_sequencer_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .cycle_abort_in(abort), .reg_wr_in(rw), .reg_rd_in(rr), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .tbl_wr_in(tw), .tbl_rd_in(tr), .tbl_high_in(hi), .tbl_byte_in(by),
    .tbl_page_in(page), .tbl_ea_in(ea), .tbl_wdata_in(wd), .tbl_rdata_out(tdata), .stall_out(stall),
    .flash_done_irq_flag_out(done), .irq_flag_clr_in(clr));
  initial forever #25 mclk_in = ~mclk_in;
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task chk(input [8*10-1:0] what, input logic [15:0] exp, input logic [15:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d); pfs_core_model_i.acc(1'b1, a, d); endtask
  task rd(input logic [15:0] a); pfs_core_model_i.acc(1'b0, a, 16'h0); endtask
  // configure, unlock back to back, then set go
  task go(input logic [15:0] c);
    begin
      wr(CT, c);
      wr(KY, 16'h0055);
      wr(KY, 16'h00aa);
      wr(CT, c | 16'h8000);
      @(negedge mclk_in);
    end
  endtask
  // bounded wait for the stall to drop
  task run_out;
    begin
      for (i = 0; i < 200 && stall; i = i + 1) @(negedge mclk_in);
      chk("stall end", 16'h0, stall);
      chk("done", 16'h1, done);
    end
  endtask
  initial begin
    repeat (4) @(negedge mclk_in);
    reset_in = 1'b0;
    rd(CT);
    chk("ctrl rst", 16'h0000, rdata);
    wr(AL, 16'h1234);
    wr(AH, 16'h0056);
    rd(AL);
    chk("adr low", 16'h1234, rdata);
    rd(AH);
    chk("adr high", 16'h0056, rdata);
    rd(KY);
    chk("key rd", 16'h0000, rdata);
    $display("test registers done");
    // one row from a row boundary, upper source byte is junk
    for (i = 0; i < 32; i = i + 1) begin
      pfs_core_model_i.tbl(1'b1, 1'b0, 8'h00, 16'(16'h0400 + 2 * i), 16'(16'ha500 + i));
      pfs_core_model_i.tbl(1'b1, 1'b1, 8'h00, 16'(16'h0400 + 2 * i), 16'(16'hff00 + i));
    end
    rd(AL);
    chk("ea low", 16'h043e, rdata);
    rd(AH);
    chk("ea high", 16'h0000, rdata);
    go(16'h4001);
    chk("stall", 16'h1, stall);
    wr(CT, 16'h4001);
    rd(CT);
    chk("go held", 16'h1, rdata[15]);
    run_out;
    rd(CT);
    chk("go clr", 16'h0, rdata[15]);
    for (i = 0; i < 32; i = i + 1) begin
      pfs_core_model_i.tbl(1'b0, 1'b0, 8'h00, 16'(16'h0400 + 2 * i), 16'h0);
      chk("row low", 16'(16'ha500 + i), tdata);
      pfs_core_model_i.tbl(1'b0, 1'b1, 8'h00, 16'(16'h0400 + 2 * i), 16'h0);
      chk("row high", 16'(i), tdata);
    end
    pfs_core_model_i.tbyte(1'b0, 16'h0403);
    chk("byte odd", 16'h00a5, tdata);
    @(negedge mclk_in) clr = 1'b1;
    @(negedge mclk_in) clr = 1'b0;
    chk("done clr", 16'h0, done);
    $display("test program done");
    go(16'h4041);
    chk("erase go", 16'h1, stall);
    run_out;
    pfs_core_model_i.tbl(1'b0, 1'b0, 8'h00, 16'h0400, 16'h0);
    chk("erased", 16'hffff, tdata);
    $display("test erase done");
    wr(CT, 16'hc001);
    @(negedge mclk_in);
    chk("no key", 16'h0, stall);
    wr(KY, 16'h0055);
    rd(CT);
    wr(KY, 16'h00aa);
    wr(CT, 16'hc001);
    @(negedge mclk_in);
    chk("key break", 16'h0, stall);
    go(16'h0001);
    chk("no enable", 16'h0, stall);
    $display("test refusals done");
    go(16'h4001);
    abort = 1'b1;
    repeat (3) @(negedge mclk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    abort = 1'b0;
    reset_in = 1'b0;
    rd(CT);
    chk("err flag", 16'h1, rdata[13]);
    rd(AL);
    chk("adr kept", 16'h0400, rdata);
    $display("test abort done");
    give_verdict;
  end
endmodule
`default_nettype wire
